// file: rtl/fcs_pkg.sv
/*
 * shared constants of the flash program sequencer: device address map,
 * command codes, bit positions, timing and the controller's register map.
 * assumes one 25 MHz clock shared by both ends.
 */
package fcs_pkg;
   // device side address map (byte addresses, 16-bit data)
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam logic [8:0] ARRAY_LIMIT = 9'h100;
   localparam logic [8:0] DEV_CTRL1_ADDR = 9'h100;
   localparam logic [8:0] DEV_STAT_ADDR = 9'h102;
   localparam int WORDS = 64;
   localparam int BLOCKS = 4;
   // control reg1 fields
   localparam int CTRL1_WIDTH_BIT = 0;
   localparam int CTRL1_LOCKDIS_BIT = 1;
   localparam int CTRL1_EW1_BIT = 2;
   localparam logic [2:0] CTRL1_RESET = 3'h0;
   // status reg fields
   localparam int STAT_PRSF_BIT = 4;
   localparam int STAT_RDY_BIT = 7;
   // command codes
   localparam logic [7:0] CMD_PROG_B = 8'h41;
   localparam logic [15:0] CMD_PROG_W = 16'h4141;
   localparam logic [7:0] CMD_LOCK = 8'h77;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [15:0] NOREAD_DATA = 16'hFFFF;
   localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
   // timing
   localparam int CLK_MHZ = 25;
   localparam int PROG_TIME_US = 150;
   localparam int LOCK_TIME_US = 150;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
   // controller registers over APB (byte offsets)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;
   localparam int GO_PROG_BIT = 0;
   localparam int GO_LOCK_BIT = 1;
   localparam int CFG_WIDTH_BIT = 2;
   localparam int CFG_LOCKDIS_BIT = 3;
   localparam int CFG_EW1_BIT = 4;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_FAIL_BIT = 1;
endpackage

// file: rtl/fcs_if.sv
/*
 * processor-to-flash write/read bus joining the two ends.
 * assumes both ends run on the same clock; req is held until ack.
 */
`timescale 1ns/100ps
interface fcs_if;
   logic req;
   logic we;
   logic [8:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;
   modport host (output req, output we, output addr, output wdata,
                 input ack, input rdata);
   modport dev (input req, input we, input addr, input wdata,
                output ack, output rdata);
endinterface

// file: rtl/fcs_flash_dev.sv
/*
 * flash array with its command sequencer, control reg1 and status reg.
 * assumes the processor holds req until ack and issues one access at a
 * time; the array is a small model with four lockable blocks.
 */
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module fcs_flash_dev
   import fcs_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // processor bus
   fcs_if.dev bus,
   // user side
   output logic busy,
   output logic [3:0] lock_state
);
   typedef enum {S_IDLE, S_DATA, S_LOCK2, S_BUSY} fcs_state_t;

   fcs_state_t state_q;
   logic ack_q;
   logic [15:0] rdata_q;
   logic [2:0] ctrl1_q;
   logic rdy_q;
   logic prsf_q;
   logic [31:0] mem_q [WORDS];
   logic [BLOCKS-1:0] lock_q;
   logic [31:0] buf_q;
   logic [5:0] widx_q;
   logic [1:0] cnt_q;
   logic lock_op_q;
   logic [11:0] tmr_q;

   logic take;
   logic wr_arr;
   logic rd_arr;
   logic width_w;
   logic [5:0] widx;
   logic [1:0] blk;
   logic last_data;
   logic [31:0] merged;
   logic refused;

   assign take = bus.req & ~ack_q;
   assign wr_arr = take & bus.we & (bus.addr < ARRAY_LIMIT);
   assign rd_arr = take & ~bus.we & (bus.addr < ARRAY_LIMIT);
   assign width_w = ctrl1_q[CTRL1_WIDTH_BIT];
   assign widx = bus.addr[7:2];
   assign blk = bus.addr[7:6];
   assign last_data = width_w ? (cnt_q == 2'd1) : (cnt_q == 2'd3);
   assign merged = mem_q[widx_q] & buf_q;
   // locked block with lock bits in effect
   assign refused = ~lock_q[blk] & ~ctrl1_q[CTRL1_LOCKDIS_BIT];

   assign bus.ack = ack_q;
   assign bus.rdata = rdata_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= take;
      end
   end

   // read data; array reads blocked during an operation
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_q <= 16'h0000;
      end else if (take & ~bus.we) begin
         if (rd_arr) begin
            if (state_q == S_BUSY) begin
               rdata_q <= NOREAD_DATA;
            end else if (bus.addr[1]) begin
               rdata_q <= mem_q[widx][31:16];
            end else begin
               rdata_q <= mem_q[widx][15:0];
            end
         end else if (bus.addr == DEV_CTRL1_ADDR) begin
            rdata_q <= {13'h0000, ctrl1_q};
         end else if (bus.addr == DEV_STAT_ADDR) begin
            rdata_q <= {8'h00, rdy_q, 2'b00, prsf_q, 4'h0};
         end else begin
            rdata_q <= 16'h0000;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl1_q <= CTRL1_RESET;
      end else if (take & bus.we & (bus.addr == DEV_CTRL1_ADDR)) begin
         ctrl1_q <= bus.wdata[2:0];
      end
   end

   // command sequencer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= S_IDLE;
         cnt_q <= 2'd0;
         widx_q <= 6'd0;
         buf_q <= ERASED_WORD;
         lock_op_q <= 1'b0;
         tmr_q <= 12'd0;
      end else begin
         case (state_q)
            S_IDLE: begin
               cnt_q <= 2'd0;
               if (wr_arr) begin
                  if (width_w ? (bus.wdata == CMD_PROG_W)
                              : (bus.wdata[7:0] == CMD_PROG_B)) begin
                     state_q <= S_DATA;
                  end else if (bus.wdata[7:0] == CMD_LOCK) begin
                     state_q <= S_LOCK2;
                  end
                  // any other code is dropped
               end
            end
            S_DATA: begin
               if (wr_arr) begin
                  if (cnt_q != 2'd0 && widx != widx_q) begin
                     state_q <= S_IDLE;
                  end else begin
                     widx_q <= widx;
                     cnt_q <= cnt_q + 2'd1;
                     if (width_w) begin
                        buf_q[cnt_q[0]*16 +: 16] <= bus.wdata;
                     end else begin
                        buf_q[cnt_q*8 +: 8] <= bus.wdata[7:0];
                     end
                     if (last_data) begin
                        lock_op_q <= 1'b0;
                        tmr_q <= 12'(PROG_CYCLES - 1);
                        state_q <= refused ? S_IDLE : S_BUSY;
                     end
                  end
               end
            end
            S_LOCK2: begin
               if (wr_arr) begin
                  widx_q <= widx;
                  lock_op_q <= 1'b1;
                  tmr_q <= 12'(LOCK_CYCLES - 1);
                  if (bus.wdata[7:0] == CMD_CONFIRM) begin
                     state_q <= S_BUSY;
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
            end
            S_BUSY: begin
               if (tmr_q == 12'd0) begin
                  state_q <= S_IDLE;
                  buf_q <= ERASED_WORD;
               end else begin
                  tmr_q <= tmr_q - 12'd1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // flash only clears bits; buffer defaults to all ones
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= ERASED_WORD;
         end
      end else if (state_q == S_BUSY && tmr_q == 12'd0 && !lock_op_q) begin
         mem_q[widx_q] <= merged;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lock_q <= {BLOCKS{1'b1}};
      end else if (state_q == S_BUSY && tmr_q == 12'd0 && lock_op_q) begin
         lock_q[widx_q[5:4]] <= 1'b0;
      end
   end

   // ready flag: low from acceptance until the operation ends
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdy_q <= 1'b1;
      end else if (state_q == S_BUSY) begin
         rdy_q <= (tmr_q == 12'd0);
      end else if (wr_arr && state_q == S_DATA && last_data && !refused &&
                   !(cnt_q != 2'd0 && widx != widx_q)) begin
         rdy_q <= 1'b0;
      end else if (wr_arr && state_q == S_LOCK2 &&
                   bus.wdata[7:0] == CMD_CONFIRM) begin
         rdy_q <= 1'b0;
      end
   end

   // result flag: 1 means the operation failed or was refused
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prsf_q <= 1'b0;
      end else if (wr_arr && state_q == S_DATA && last_data && refused &&
                   !(cnt_q != 2'd0 && widx != widx_q)) begin
         prsf_q <= 1'b1;
      end else if (state_q == S_BUSY && tmr_q == 12'd0) begin
         if (lock_op_q) begin
            prsf_q <= 1'b0;
         end else begin
            prsf_q <= (merged != buf_q);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busy <= 1'b0;
         lock_state <= {BLOCKS{1'b1}};
      end else begin
         busy <= ~rdy_q;
         lock_state <= lock_q;
      end
   end
endmodule

// file: rtl/fcs_flash_host.sv
/*
 * controller that drives the flash command sequence on software's order.
 * assumes an APB master on the register side and the flash end on bus.
 */
`timescale 1ns/100ps
module fcs_flash_host
   import fcs_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   // interrupt
   output logic irq,
   // flash bus
   fcs_if.host bus
);
   typedef enum {H_IDLE, H_CFG, H_CMD, H_DATA, H_POLL} fcs_hstate_t;

   fcs_hstate_t st_q;
   logic [2:0] cfg_q;
   logic [8:0] tgt_q;
   logic [31:0] data_q;
   logic lock_op_q;
   logic [1:0] idx_q;
   logic fail_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic req_q;
   logic we_q;
   logic [8:0] addr_q;
   logic [15:0] wdata_q;
   logic wr_acc;
   logic go;
   logic done_ev;
   logic last_idx;
   logic [15:0] dword;

   assign wr_acc = psel & penable & pready & pwrite;
   assign go = wr_acc & (paddr == REG_CTRL) & (st_q == H_IDLE);
   assign last_idx = lock_op_q | (cfg_q[0] ? idx_q == 2'd1 : idx_q == 2'd3);
   assign dword = lock_op_q ? {8'h00, CMD_CONFIRM} :
                  cfg_q[0] ? data_q[idx_q[0]*16 +: 16] :
                  {8'h00, data_q[idx_q*8 +: 8]};
   assign done_ev = (st_q == H_POLL) & bus.ack & bus.rdata[STAT_RDY_BIT];
   assign bus.req = req_q;
   assign bus.we = we_q;
   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;

   // apb answers in the first cycle of the access phase, no wait state
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & ~penable;
         case (paddr)
            REG_CTRL: prdata <= {27'h0, cfg_q[2], cfg_q[1], cfg_q[0], 2'b00};
            REG_ADDR: prdata <= {23'h0, tgt_q};
            REG_DATA: prdata <= data_q;
            REG_STAT: prdata <= {30'h0, fail_q, st_q != H_IDLE};
            REG_IRQ_STAT: prdata <= {30'h0, irq_stat_q};
            REG_IRQ_MASK: prdata <= {30'h0, irq_mask_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // configuration is frozen while a sequence runs; the irq mask stays writable
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cfg_q <= CTRL1_RESET;
         tgt_q <= 9'h000;
         data_q <= 32'h00000000;
         lock_op_q <= 1'b0;
         irq_mask_q <= 2'b00;
      end else if (wr_acc) begin
         if (go) begin
            cfg_q <= {pwdata[CFG_EW1_BIT], pwdata[CFG_LOCKDIS_BIT],
                      pwdata[CFG_WIDTH_BIT]};
            lock_op_q <= pwdata[GO_LOCK_BIT] & ~pwdata[GO_PROG_BIT];
         end
         if (paddr == REG_ADDR && st_q == H_IDLE) begin
            tgt_q <= {1'b0, pwdata[7:2], 2'b00};
         end
         if (paddr == REG_DATA && st_q == H_IDLE) begin
            data_q <= pwdata;
         end
         if (paddr == REG_IRQ_MASK) begin
            irq_mask_q <= pwdata[1:0];
         end
      end
   end

   // sequence of bus accesses, each held until ack
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q <= H_IDLE;
         idx_q <= 2'd0;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 9'h000;
         wdata_q <= 16'h0000;
         fail_q <= 1'b0;
      end else if (bus.ack) begin
         req_q <= 1'b0;
         case (st_q)
            H_CFG: st_q <= H_CMD;
            H_CMD: st_q <= H_DATA;
            H_DATA: begin
               idx_q <= idx_q + 2'd1;
               if (last_idx) begin
                  st_q <= H_POLL;
               end
            end
            H_POLL: begin
               if (bus.rdata[STAT_RDY_BIT]) begin
                  fail_q <= bus.rdata[STAT_PRSF_BIT];
                  st_q <= H_IDLE;
               end
            end
            default: st_q <= H_IDLE;
         endcase
      end else if (!req_q) begin
         case (st_q)
            H_IDLE: begin
               idx_q <= 2'd0;
               if (go && (pwdata[GO_PROG_BIT] || pwdata[GO_LOCK_BIT])) begin
                  st_q <= H_CFG;
               end
            end
            H_CFG: begin
               req_q <= 1'b1;
               we_q <= 1'b1;
               addr_q <= DEV_CTRL1_ADDR;
               wdata_q <= {13'h0000, cfg_q};
            end
            H_CMD: begin
               req_q <= 1'b1;
               we_q <= 1'b1;
               addr_q <= tgt_q;
               if (lock_op_q) begin
                  wdata_q <= {8'h00, CMD_LOCK};
               end else if (cfg_q[0]) begin
                  wdata_q <= CMD_PROG_W;
               end else begin
                  wdata_q <= {8'h00, CMD_PROG_B};
               end
            end
            H_DATA: begin
               req_q <= 1'b1;
               we_q <= 1'b1;
               addr_q <= tgt_q;
               wdata_q <= dword;
            end
            H_POLL: begin
               req_q <= 1'b1;
               we_q <= 1'b0;
               addr_q <= DEV_STAT_ADDR;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // sticky events, write one to clear, set wins
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_stat_q <= 2'b00;
      end else begin
         irq_stat_q <= (irq_stat_q &
            ~((wr_acc && paddr == REG_IRQ_STAT) ? pwdata[1:0] : 2'b00)) |
            {done_ev & bus.rdata[STAT_PRSF_BIT], done_ev};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule

// file: bench/fcs_bus_props.sv
/* interface checker for the flash program sequencer.
   assumes one clock and a sync reset shared with both ends. */
`timescale 1ns/100ps
module fcs_bus_props
   import fcs_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // processor bus
   input wire logic req,
   input wire logic we,
   input wire logic [8:0] addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [15:0] rdata,
   // device user side
   input wire logic busy,
   input wire logic [3:0] lock_state
);
   logic [12:0] run_q;
   logic rst_q;

   // reset lingers one edge: outputs cleared by reset show as changes
   always_ff @(posedge sys_clk) begin
      rst_q <= sys_rst;
   end

   // length of the current busy stretch, zero while idle
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !busy) begin
         run_q <= 13'h0000;
      end else begin
         run_q <= run_q + 13'h0001;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst || rst_q);

   sequence take_s;
      req && !ack;
   endsequence

   sequence stat_rd_s;
      req && !ack && !we && addr == DEV_STAT_ADDR;
   endsequence

   ack_after_take_a: assert property (take_s |=> ack)
      else $error("no answer one cycle after request");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("answer longer than one cycle");
   ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
      else $error("answer without request");
   ready_flag_a: assert property (stat_rd_s |=>
      rdata[STAT_RDY_BIT] == !busy)
      else $error("ready flag disagrees with busy");
   busy_start_a: assert property ($rose(busy) |->
      $past(ack) && $past(req, 2) && $past(we, 2)
      && $past(addr, 2) < ARRAY_LIMIT)
      else $error("busy rose without final write");
   busy_len_a: assert property ($fell(busy) |->
      run_q >= PROG_CYCLES - 2 && run_q <= PROG_CYCLES + 2)
      else $error("busy stretch has wrong length");
   lock_change_a: assert property ($changed(lock_state) |->
      $past(busy) && $countones(lock_state ^ $past(lock_state)) == 1
      && (lock_state & ~$past(lock_state)) == 4'h0)
      else $error("lock bits changed outside a lock operation");
   rdata_hold_a: assert property (!(req && !ack && !we) |=>
      $stable(rdata))
      else $error("read data moved without a read");
endmodule

// file: bench/testbench.sv
/* self-checking bench joining both ends of the flash program sequencer.
   assumes the package map; the bench is the APB master. */
`timescale 1ns/100ps
module testbench
   import fcs_pkg::*;
;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic irq;
   logic busy;
   logic [3:0] lock_state;
   logic [15:0] lfsr_q = 16'hE269;
   int bad_count = 0;
   int n_tests = 0;
   int busy_cycles = 0;
   logic [31:0] mem [64];
   int lk [4];
   // lock, width, lock disable, mode1, irq mask[1:0], address[7:0]
   logic [13:0] ops [7] = '{
      14'h1313,
      14'h0724,
      14'h2347,
      14'h30B0,
      14'h1348,
      14'h094C,
      14'h02F8
   };

   always #20 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      if (busy === 1'b1) begin
         busy_cycles <= busy_cycles + 1;
      end
   end

   fcs_if u_fcs_if ();

   fcs_flash_dev u_fcs_flash_dev (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .bus(u_fcs_if), .busy(busy), .lock_state(lock_state));

   fcs_flash_host u_fcs_flash_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .irq(irq),
      .bus(u_fcs_if));

   fcs_bus_props u_fcs_bus_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .req(u_fcs_if.req), .we(u_fcs_if.we), .addr(u_fcs_if.addr),
      .wdata(u_fcs_if.wdata), .ack(u_fcs_if.ack),
      .rdata(u_fcs_if.rdata), .busy(busy), .lock_state(lock_state));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      apb(1'b0, a, 32'h00000000, x);
      check(x, e);
   endtask

   // one program or lock operation, judged against the array model
   task automatic run_op(input logic [13:0] op);
      logic [31:0] d;
      logic [31:0] r;
      logic fail;
      logic acc;
      int blk;
      int base;
      logic [3:0] lkv;
      d = {lfsr_q, lfsr_next(lfsr_q)};
      lfsr_q = lfsr_next(lfsr_next(lfsr_q));
      blk = int'(op[7:6]);
      fail = 1'b0;
      acc = 1'b1;
      if (op[13]) begin
         lk[blk] = 0;
      end else if (!op[11] && lk[blk] == 0) begin
         fail = 1'b1;
         acc = 1'b0;
      end else begin
         fail = (mem[op[7:2]] & d) != d;
         mem[op[7:2]] = mem[op[7:2]] & d;
      end
      base = busy_cycles;
      wr(REG_IRQ_MASK, {30'h0, op[9:8]});
      wr(REG_ADDR, {24'h00, op[7:0]});
      wr(REG_DATA, d);
      wr(REG_CTRL, {27'h0, op[10], op[11], op[12], op[13], !op[13]});
      do apb(1'b0, REG_STAT, 32'h00000000, r); while (r[0] !== 1'b0);
      check(r, {30'h0, fail, 1'b0});
      check({31'h0, busy_cycles > base}, {31'h0, acc});
      rd_chk(REG_IRQ_STAT, {30'h0, fail, 1'b1});
      check({31'h0, irq}, {31'h0, |({fail, 1'b1} & op[9:8])});
      wr(REG_IRQ_STAT, 32'h00000001);
      rd_chk(REG_IRQ_STAT, {30'h0, fail, 1'b0});
      wr(REG_IRQ_STAT, 32'h00000002);
      rd_chk(REG_IRQ_STAT, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      lkv = {lk[3] != 0, lk[2] != 0, lk[1] != 0, lk[0] != 0};
      check({28'h0, lock_state}, {28'h0, lkv});
      rd_chk(REG_CTRL, {27'h0, op[10], op[11], op[12], 2'b00});
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 32'hFFFFFFFF;
      for (int i = 0; i < 4; i++) lk[i] = 1;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // every mapped register and two unmapped words read zero
      for (int a = 0; a < 32; a += 4) rd_chk(8'(a), 32'h00000000);
      check({28'h0, lock_state}, 32'h0000000F);
      // distinct words only, so nothing is programmed twice
      foreach (ops[i]) run_op(ops[i]);
      // reset in the middle of a lock operation
      wr(REG_CTRL, 32'h00000002);
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd_chk(REG_STAT, 32'h00000000);
      check({28'h0, lock_state}, 32'h0000000F);
      tally_and_finish();
   end
endmodule
